// *** common/cfrv_pkg.sv ***
package cfrv_pkg;

   // ----------------------------------------------------------------
   // Reset vectors
   // ----------------------------------------------------------------
   localparam logic [15:0] VEC_NORM_EXT = 16'hfffe;
   localparam logic [15:0] VEC_NORM_CLK = 16'hfffc;
   localparam logic [15:0] VEC_NORM_WDT = 16'hfffa;
   localparam logic [15:0] VEC_BOOT_EXT = 16'hbffe;
   localparam logic [15:0] VEC_BOOT_CLK = 16'hbffc;
   localparam logic [15:0] VEC_BOOT_WDT = 16'hbffa;
   localparam logic [15:0] PC_RESET     = 16'h0000;

   // ----------------------------------------------------------------
   // Flag byte layout
   // ----------------------------------------------------------------
   localparam int FB_C = 0;
   localparam int FB_V = 1;
   localparam int FB_Z = 2;
   localparam int FB_N = 3;
   localparam int FB_I = 4;
   localparam int FB_H = 5;
   localparam int FB_X = 6;
   localparam int FB_S = 7;
   localparam logic [7:0] FLAG_RESET = 8'hd0;

   // ----------------------------------------------------------------
   // Opcode pages
   // ----------------------------------------------------------------
   localparam logic [7:0] PREBYTE_P1 = 8'h18;
   localparam logic [7:0] PREBYTE_P2 = 8'h1a;
   localparam logic [7:0] PREBYTE_P3 = 8'hcd;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_KEEP   = 4'h0,
      OP_LDST   = 4'h1,
      OP_ADD    = 4'h2,
      OP_ADC    = 4'h3,
      OP_SUB    = 4'h4,
      OP_SBC    = 4'h5,
      OP_CMP    = 4'h6,
      OP_LOGIC  = 4'h7,
      OP_SHL    = 4'h8,
      OP_SHR    = 4'h9,
      OP_MULDIV = 4'ha,
      OP_IDX    = 4'hb,
      OP_TAP    = 4'hc,
      OP_RTI    = 4'hd,
      OP_STOP   = 4'he
   } cfrv_op_kind_type;

   typedef struct packed {
      logic             valid;
      cfrv_op_kind_type kind;
      logic             rotate;
      logic             error;
      logic [7:0]       opa;
      logic [7:0]       opb;
      logic [15:0]      idx;
   } cfrv_op_type;

   typedef struct packed {
      logic test_boot;
      logic clk_mon;
      logic wdt;
   } cfrv_cause_type;

   typedef struct packed {
      logic        rd;
      logic [15:0] addr;
   } cfrv_mem_req_type;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } cfrv_byte_type;

endpackage

// *** core/cfrv_core.sv ***
`timescale 1ns/1ps
// Behaviour
// - Sixteen-bit pointer holds next fetch address
// - Normal mode vectors FFFE, FFFC, FFFA
// - Test/boot vectors BFFE, BFFC, BFFA, high first
// - Eight-bit flag byte, five indicators, three controls
// - Stack, index add, transfers keep flags
// - Load and store update N, Z, V
// - Carry from arithmetic, errors, shifts
// - Overflow on two's-complement overflow
// - Zero on zero result; compare not stored
// - Index increment/decrement touches only zero
// - Negative copies result most significant bit
// - Global mask blocks maskable, pending kept
// - Reset sets global mask; hardware never clears
// - Stack, then set mask, then vector
// - Half carry from bit 3 on adds
// - Pin mask blocks pin; reset sets it
// - Pin interrupt sets both masks after stacking
// - Pin mask set only by hardware
// - Pin mask cleared only by transfer or return
// - Stop disable makes stop a no-operation
// - Words big-endian, no alignment needed
// - Prebyte selects opcode page one to three
module cfrv_core #(
   parameter logic [7:0] PRE_P2 = cfrv_pkg::PREBYTE_P2,
   parameter logic [7:0] PRE_P3 = cfrv_pkg::PREBYTE_P3
) (
   input  wire logic                     sys_clk,
   input  wire logic                     rst_n,
   input  wire cfrv_pkg::cfrv_cause_type cause,
   output cfrv_pkg::cfrv_mem_req_type    mem_req,
   input  wire logic                     mem_ack,
   input  wire logic [7:0]               mem_rdata,
   input  wire logic                     pc_load,
   input  wire logic [15:0]              pc_value,
   input  wire logic                     pc_advance,
   output logic [15:0]                   next_fetch_pointer,
   output logic                          vector_done,
   input  wire cfrv_pkg::cfrv_op_type    op,
   output logic [7:0]                    flag_byte,
   output logic [7:0]                    op_result,
   output logic                          op_result_valid,
   output logic                          stop_enter,
   input  wire logic                     irq_pending,
   input  wire logic                     nonmaskable_req_pin_n,
   output logic                          irq_allowed,
   output logic                          nmi_allowed,
   input  wire logic                     intr_recognized,
   input  wire logic                     intr_is_pin,
   output logic                          stack_req,
   input  wire logic                     stack_done,
   output logic                          intr_vector_fetch,
   input  wire cfrv_pkg::cfrv_byte_type  fetch_byte,
   output logic [1:0]                    opcode_page,
   output logic [7:0]                    opcode,
   output logic                          opcode_valid
);
   import cfrv_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef enum logic [6:0] {
      S_CAPT  = 7'b0000001,
      S_VHI   = 7'b0000010,
      S_VLO   = 7'b0000100,
      S_RUN   = 7'b0001000,
      S_STACK = 7'b0010000,
      S_MASK  = 7'b0100000,
      S_VECT  = 7'b1000000
   } cfrv_state_type;

   cfrv_state_type state_q;
   cfrv_state_type state_d;

   logic [15:0] vec_addr_q;
   logic [15:0] pc_q;
   logic [15:0] pc_d;
   logic [7:0]  flags_q;
   logic [7:0]  flags_d;
   logic [7:0]  res_q;
   logic        res_valid_q;
   logic        stop_q;
   logic        pin_mask_q;
   logic        pin_sync1_q;
   logic        pin_sync2_q;
   logic        pre_seen_q;
   logic [1:0]  page_q;
   logic [7:0]  opc_q;
   logic        opc_valid_q;

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   function automatic logic [15:0] vec_sel(input cfrv_cause_type c);
      logic [15:0] v;
      if (c.test_boot) begin
         v = c.wdt ? VEC_BOOT_WDT :
             c.clk_mon ? VEC_BOOT_CLK : VEC_BOOT_EXT;
      end else begin
         v = c.wdt ? VEC_NORM_WDT :
             c.clk_mon ? VEC_NORM_CLK : VEC_NORM_EXT;
      end
      return v;
   endfunction

   function automatic logic [2:0] page_of(input logic [7:0] b);
      logic [2:0] p;
      p = 3'b000;
      if (b == PREBYTE_P1) begin
         p = 3'b101;
      end else if (b == PRE_P2) begin
         p = 3'b110;
      end else if (b == PRE_P3) begin
         p = 3'b111;
      end
      return p;
   endfunction

   // ----------------------------------------------------------------
   // Flag calculation
   // ----------------------------------------------------------------
   logic [7:0] calc_flags;
   logic [7:0] calc_res;
   logic       calc_we;

   cfrv_flag_calc u_calc (
      .op        (op),
      .flags_in  (flags_q),
      .flags_out (calc_flags),
      .result    (calc_res),
      .result_we (calc_we)
   );

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   wire logic in_run    = (state_q == S_RUN);
   wire logic op_fire   = in_run & op.valid;
   wire logic stop_req  = op_fire & (op.kind == OP_STOP);
   wire logic stop_go   = stop_req & ~flags_q[FB_S];
   wire logic pin_req   = ~pin_sync2_q;
   wire logic take_intr = in_run & intr_recognized;
   wire logic [2:0] pg  = page_of(fetch_byte.data);
   wire logic is_pre    = pg[2] & ~pre_seen_q;

   assign irq_allowed = irq_pending & ~flags_q[FB_I];
   assign nmi_allowed = pin_req & ~flags_q[FB_X];
   assign stack_req   = (state_q == S_STACK);
   assign intr_vector_fetch = (state_q == S_VECT);
   assign vector_done = (state_q == S_VLO) & mem_ack;
   assign mem_req.rd  = (state_q == S_VHI) | (state_q == S_VLO);
   assign mem_req.addr = (state_q == S_VLO) ? (vec_addr_q + 16'h0001)
                                            : vec_addr_q;

   assign next_fetch_pointer = pc_q;
   assign flag_byte          = flags_q;
   assign op_result          = res_q;
   assign op_result_valid    = res_valid_q;
   assign stop_enter         = stop_q;
   assign opcode_page        = page_q;
   assign opcode             = opc_q;
   assign opcode_valid       = opc_valid_q;

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         S_CAPT: begin
            state_d = S_VHI;
         end
         S_VHI: begin
            if (mem_ack) begin
               state_d = S_VLO;
            end
         end
         S_VLO: begin
            if (mem_ack) begin
               state_d = S_RUN;
            end
         end
         S_RUN: begin
            if (take_intr) begin
               state_d = S_STACK;
            end
         end
         S_STACK: begin
            if (stack_done) begin
               state_d = S_MASK;
            end
         end
         S_MASK: begin
            state_d = S_VECT;
         end
         S_VECT: begin
            state_d = S_RUN;
         end
         default: begin
            state_d = S_CAPT;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Next fetch pointer
   // ----------------------------------------------------------------
   always_comb begin
      pc_d = pc_q;
      if ((state_q == S_VHI) && mem_ack) begin
         pc_d = {mem_rdata, pc_q[7:0]};
      end else if ((state_q == S_VLO) && mem_ack) begin
         pc_d = {pc_q[15:8], mem_rdata};
      end else if (pc_load) begin
         pc_d = pc_value;
      end else if (pc_advance) begin
         pc_d = pc_q + 16'h0001;
      end
   end

   // ----------------------------------------------------------------
   // Flag byte
   // ----------------------------------------------------------------
   always_comb begin
      flags_d = flags_q;
      if (state_q == S_MASK) begin
         flags_d[FB_I] = 1'b1;
         if (pin_mask_q) begin
            flags_d[FB_X] = 1'b1;
         end
      end else if (op_fire) begin
         flags_d = calc_flags;
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= S_CAPT;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         vec_addr_q <= VEC_NORM_EXT;
      end else if (state_q == S_CAPT) begin
         vec_addr_q <= vec_sel(cause);
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pc_q <= PC_RESET;
      end else begin
         pc_q <= pc_d;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         flags_q <= FLAG_RESET;
      end else begin
         flags_q <= flags_d;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_mask_q <= 1'b0;
      end else if (take_intr) begin
         pin_mask_q <= intr_is_pin;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         res_q       <= 8'h00;
         res_valid_q <= 1'b0;
         stop_q      <= 1'b0;
      end else begin
         res_valid_q <= op_fire & calc_we;
         stop_q      <= stop_go;
         if (op_fire && calc_we) begin
            res_q <= calc_res;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_sync1_q <= 1'b1;
         pin_sync2_q <= 1'b1;
      end else begin
         pin_sync1_q <= nonmaskable_req_pin_n;
         pin_sync2_q <= pin_sync1_q;
      end
   end

   // ----------------------------------------------------------------
   // Opcode page tracking
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_seen_q  <= 1'b0;
         page_q      <= 2'b00;
         opc_q       <= 8'h00;
         opc_valid_q <= 1'b0;
      end else begin
         opc_valid_q <= fetch_byte.valid & ~is_pre;
         if (fetch_byte.valid) begin
            if (is_pre) begin
               pre_seen_q <= 1'b1;
               page_q     <= pg[1:0];
            end else begin
               pre_seen_q <= 1'b0;
               opc_q      <= fetch_byte.data;
               if (!pre_seen_q) begin
                  page_q <= 2'b00;
               end
            end
         end
      end
   end

endmodule

// *** core/cfrv_flag_calc.sv ***
`timescale 1ns/1ps
module cfrv_flag_calc (
   input  wire cfrv_pkg::cfrv_op_type op,
   input  wire logic [7:0]            flags_in,
   output logic [7:0]                 flags_out,
   output logic [7:0]                 result,
   output logic                       result_we
);
   import cfrv_pkg::*;

   // ----------------------------------------------------------------
   // Arithmetic
   // ----------------------------------------------------------------
   function automatic logic [11:0] arith(input logic [7:0] a,
                                         input logic [7:0] b,
                                         input logic       cin,
                                         input logic       sub);
      logic [8:0] s;
      logic       v;
      logic       h;
      s = sub ? ({1'b0, a} - {1'b0, b} - {8'h00, cin})
              : ({1'b0, a} + {1'b0, b} + {8'h00, cin});
      v = sub ? ((a[7] != b[7]) & (s[7] != a[7]))
              : ((a[7] == b[7]) & (s[7] != a[7]));
      h = a[4] ^ b[4] ^ s[4];
      return {1'b0, h, v, s[8], s[7:0]};
   endfunction

   wire logic        cin   = flags_in[FB_C];
   wire logic        is_sb = (op.kind == OP_SUB) | (op.kind == OP_SBC)
                           | (op.kind == OP_CMP);
   wire logic        use_c = (op.kind == OP_ADC) | (op.kind == OP_SBC);
   wire logic [11:0] ar    = arith(op.opa, op.opb, use_c & cin, is_sb);
   wire logic        fill  = op.rotate & cin;
   wire logic [7:0]  shl   = {op.opa[6:0], fill};
   wire logic [7:0]  shr   = {fill, op.opa[7:1]};

   // ----------------------------------------------------------------
   // Flag update
   // ----------------------------------------------------------------
   always_comb begin
      flags_out = flags_in;
      result    = op.opa;
      result_we = 1'b0;
      unique case (op.kind)
         OP_LDST, OP_LOGIC: begin
            flags_out[FB_N] = op.opa[7];
            flags_out[FB_Z] = (op.opa == 8'h00);
            flags_out[FB_V] = 1'b0;
            result_we       = 1'b1;
         end
         OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_CMP: begin
            result          = ar[7:0];
            flags_out[FB_N] = ar[7];
            flags_out[FB_Z] = (ar[7:0] == 8'h00);
            flags_out[FB_C] = ar[8];
            flags_out[FB_V] = ar[9];
            if (!is_sb) begin
               flags_out[FB_H] = ar[10];
            end
            result_we = (op.kind != OP_CMP);
         end
         OP_SHL, OP_SHR: begin
            result          = (op.kind == OP_SHL) ? shl : shr;
            flags_out[FB_C] = (op.kind == OP_SHL) ? op.opa[7]
                                                  : op.opa[0];
            flags_out[FB_N] = result[7];
            flags_out[FB_Z] = (result == 8'h00);
            flags_out[FB_V] = result[7] ^ flags_out[FB_C];
            result_we       = 1'b1;
         end
         OP_MULDIV: begin
            flags_out[FB_C] = op.error;
         end
         OP_IDX: begin
            flags_out[FB_Z] = (op.idx == 16'h0000);
         end
         OP_TAP, OP_RTI: begin
            flags_out = op.opa;
            flags_out[FB_X] = flags_in[FB_X] & op.opa[FB_X];
         end
         OP_KEEP, OP_STOP: begin
            flags_out = flags_in;
         end
         default: begin
            flags_out = flags_in;
         end
      endcase
   end

endmodule

// *** tb/cfrv_core_sva.sv ***
`timescale 1ns/1ps
module cfrv_core_sva (
   input wire logic                       sys_clk,
   input wire logic                       rst_n,
   input wire cfrv_pkg::cfrv_mem_req_type mem_req,
   input wire logic                       mem_ack,
   input wire logic                       vector_done,
   input wire cfrv_pkg::cfrv_op_type      op,
   input wire logic [7:0]                 flag_byte,
   input wire logic                       op_result_valid,
   input wire logic                       stop_enter,
   input wire logic                       irq_pending,
   input wire logic                       irq_allowed,
   input wire logic                       nmi_allowed,
   input wire logic                       stack_req,
   input wire logic                       stack_done,
   input wire logic                       intr_vector_fetch
);
   import cfrv_pkg::*;
   // ----------------------------------------------------------------
   // Run state tracking
   // ----------------------------------------------------------------
   logic       run_q;
   logic       mask_q;
   logic       op_ok;
   logic [4:0] low_sum;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         run_q  <= 1'b0;
         mask_q <= 1'b0;
      end else begin
         run_q  <= run_q | vector_done;
         mask_q <= stack_req & stack_done;
      end
   end
   assign op_ok = op.valid & run_q & ~stack_req & ~intr_vector_fetch & ~mask_q;
   assign low_sum = {1'b0, op.opa[3:0]} + {1'b0, op.opb[3:0]};
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   a_irq_gate: assert property (
      irq_allowed == (irq_pending && !flag_byte[FB_I]))
      else $error("maskable gate wrong");
   a_nmi_block: assert property (
      flag_byte[FB_X] |-> !nmi_allowed) else $error("pin not masked");
   a_mask_before_vec: assert property (
      stack_req && stack_done |-> ##2 intr_vector_fetch && flag_byte[FB_I])
      else $error("mask or vector fetch late");
   a_i_hw_hold: assert property (
      $fell(flag_byte[FB_I]) |-> $past(op.valid && op.kind inside
      {OP_TAP, OP_RTI})) else $error("global mask cleared by hardware");
   a_x_hw_set: assert property (
      $rose(flag_byte[FB_X]) |-> intr_vector_fetch)
      else $error("pin mask set outside entry");
   a_x_sw_clear: assert property (
      $fell(flag_byte[FB_X]) |-> $past(op.valid && !op.opa[6] &&
      op.kind inside {OP_TAP, OP_RTI})) else $error("pin mask clear bad");
   a_idx_z_only: assert property (
      op_ok && op.kind == OP_IDX |=> (flag_byte & 8'hfb) ==
      ($past(flag_byte) & 8'hfb)) else $error("index op moved flags");
   a_keep_flags: assert property (
      op_ok && op.kind == OP_KEEP |=> $stable(flag_byte))
      else $error("neutral op moved flags");
   a_half_carry: assert property (
      op_ok && op.kind == OP_ADD |=> flag_byte[FB_H] == $past(low_sum[4]))
      else $error("half carry wrong");
   a_ldst_nzv: assert property (
      op_ok && op.kind == OP_LDST |=> flag_byte[FB_N] == $past(op.opa[7])
      && !flag_byte[FB_V] && op_result_valid) else $error("load flags bad");
   a_stop_nop: assert property (
      op_ok && op.kind == OP_STOP |=> stop_enter == !$past(flag_byte[FB_S]))
      else $error("stop gating wrong");
   a_vec_next: assert property (
      mem_req.rd && mem_ack && !vector_done |=> mem_req.rd &&
      mem_req.addr == $past(mem_req.addr) + 16'h0001)
      else $error("low vector byte address wrong");
   c_vec: cover property (vector_done);
   c_entry: cover property (intr_vector_fetch);
   c_stop: cover property (stop_enter);
endmodule

// *** tb/cfrv_core_tb_top.sv ***
`timescale 1ns/1ps
module cfrv_core_tb_top;
   import cfrv_pkg::*;
   typedef struct packed {
      cfrv_op_kind_type kind;
      logic             rot;
      logic             err;
      logic [7:0]       a, b, res;
      logic             wr;
      logic [7:0]       fl;
   } cfrv_row_type;
   // ----------------------------------------------------------------
   // Signals and instance
   // ----------------------------------------------------------------
   logic             sys_clk, rst_n, mem_ack, pc_load, pc_advance;
   logic             irq_pending, nonmaskable_req_pin_n, intr_recognized;
   logic             intr_is_pin, stack_done, vector_done, op_result_valid;
   logic             stop_enter, irq_allowed, nmi_allowed, stack_req;
   logic             intr_vector_fetch, opcode_valid;
   logic [1:0]       opcode_page;
   logic [7:0]       mem_rdata, flag_byte, op_result, opcode;
   logic [15:0]      pc_value, next_fetch_pointer;
   cfrv_cause_type   cause;
   cfrv_mem_req_type mem_req;
   cfrv_op_type      op;
   cfrv_byte_type    fetch_byte;
   int               n_mismatch = 0;
   int               checks = 0;
   cfrv_core cfrv_core_i (.sys_clk, .rst_n, .cause, .mem_req, .mem_ack,
      .mem_rdata, .pc_load, .pc_value, .pc_advance, .next_fetch_pointer,
      .vector_done, .op, .flag_byte, .op_result, .op_result_valid,
      .stop_enter, .irq_pending, .nonmaskable_req_pin_n, .irq_allowed,
      .nmi_allowed, .intr_recognized, .intr_is_pin, .stack_req, .stack_done,
      .intr_vector_fetch, .fetch_byte, .opcode_page, .opcode, .opcode_valid);
   cfrv_row_type rows[13] = '{
      '{OP_ADD,    0, 0, 8'h08, 8'h08, 8'h10, 1, 8'h20},
      '{OP_ADD,    0, 0, 8'h80, 8'h80, 8'h00, 1, 8'h07},
      '{OP_ADC,    0, 0, 8'h01, 8'h01, 8'h03, 1, 8'h00},
      '{OP_SUB,    0, 0, 8'h00, 8'h01, 8'hff, 1, 8'h09},
      '{OP_SBC,    0, 0, 8'h80, 8'h00, 8'h7f, 1, 8'h02},
      '{OP_CMP,    0, 0, 8'h05, 8'h05, 8'h00, 0, 8'h04},
      '{OP_LDST,   0, 0, 8'h80, 8'h00, 8'h80, 1, 8'h08},
      '{OP_LOGIC,  0, 0, 8'h00, 8'h00, 8'h00, 1, 8'h04},
      '{OP_SHL,    0, 0, 8'h81, 8'h00, 8'h02, 1, 8'h03},
      '{OP_SHR,    1, 0, 8'h01, 8'h00, 8'h80, 1, 8'h09},
      '{OP_MULDIV, 0, 1, 8'h00, 8'h00, 8'h00, 0, 8'h09},
      '{OP_IDX,    0, 0, 8'h00, 8'h00, 8'h00, 0, 8'h0d},
      '{OP_ADD,    0, 0, 8'h7f, 8'h01, 8'h80, 1, 8'h2a}};
   cfrv_cause_type cz[7] = '{3'b010, 3'b001, 3'b011, 3'b100, 3'b110,
                             3'b101, 3'b000};
   logic [15:0]    vz[7] = '{16'hfffc, 16'hfffa, 16'hfffa, 16'hbffe,
                             16'hbffc, 16'hbffa, 16'hfffe};
   logic [7:0]     pre[4] = '{8'h00, PREBYTE_P1, PREBYTE_P2, PREBYTE_P3};
   bit             seen;
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] s, e);
      checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic guard(input int n);
      if (n >= 20) begin
         n_mismatch++;
         complete_run();
      end
   endtask
   task automatic boot(input cfrv_cause_type c, input logic [15:0] v);
      int n = 0;
      rst_n = 1'b0;
      cause = c;
      repeat (4) @(negedge sys_clk);
      chk("rst_flags", flag_byte, 8'hd0);
      rst_n = 1'b1;
      while (mem_req.rd !== 1'b1 && n < 20) begin
         @(negedge sys_clk);
         n++;
      end
      guard(n);
      chk("vec_hi", mem_req.addr, v);
      mem_ack = 1'b1;
      mem_rdata = v[7:0];
      @(negedge sys_clk);
      chk("vec_lo", mem_req.addr, v + 16'h0001);
      mem_rdata = v[15:8];
      #1 chk("vec_done", vector_done, 1'b1);
      @(negedge sys_clk);
      mem_ack = 1'b0;
      chk("pointer", next_fetch_pointer, {v[7:0], v[15:8]});
   endtask
   task automatic run_op(input cfrv_op_kind_type k, input logic [7:0] a);
      op = '{1'b1, k, 1'b0, 1'b0, a, 8'h00, 16'h0000};
      @(negedge sys_clk);
   endtask
   task automatic feed(input logic [7:0] b);
      fetch_byte = '{1'b1, b};
      @(negedge sys_clk);
   endtask
   task automatic wait_on(input int w);
      int n = 0;
      seen = 1'b0;
      while (!seen && n < 20) begin
         seen = (w == 0) ? (stack_req === 1'b1) : (intr_vector_fetch === 1'b1);
         if (!seen) @(negedge sys_clk);
         n++;
      end
      guard(seen ? 0 : 20);
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      {mem_ack, pc_load, pc_advance, intr_recognized} = 4'h0;
      {intr_is_pin, stack_done} = 2'h0;
      irq_pending = 1'b1;
      nonmaskable_req_pin_n = 1'b1;
      mem_rdata = 8'h00;
      pc_value = 16'h0000;
      op = '0;
      fetch_byte = '0;
      for (int i = 0; i < 7; i++) boot(cz[i], vz[i]);
      for (int i = 0; i < 13; i++) begin
         op = '{1'b1, rows[i].kind, rows[i].rot, rows[i].err, rows[i].a,
                rows[i].b, 16'h0000};
         @(negedge sys_clk);
         chk("flags", flag_byte, 8'hd0 | rows[i].fl);
         chk("res_valid", op_result_valid, rows[i].wr);
         if (rows[i].wr) chk("result", op_result, rows[i].res);
      end
      run_op(OP_STOP, 8'h00);
      chk("stop_off", stop_enter, 1'b0);
      chk("irq_masked", irq_allowed, 1'b0);
      run_op(OP_TAP, 8'h00);
      chk("tap_clear", flag_byte, 8'h00);
      chk("irq_open", irq_allowed, 1'b1);
      run_op(OP_STOP, 8'h00);
      chk("stop_on", stop_enter, 1'b1);
      run_op(OP_TAP, 8'hff);
      chk("tap_set", flag_byte, 8'hbf);
      run_op(OP_RTI, 8'h00);
      chk("rti_load", flag_byte, 8'h00);
      op.valid = 1'b0;
      nonmaskable_req_pin_n = 1'b0;
      repeat (3) @(negedge sys_clk);
      chk("nmi_open", nmi_allowed, 1'b1);
      intr_recognized = 1'b1;
      intr_is_pin = 1'b1;
      @(negedge sys_clk);
      intr_recognized = 1'b0;
      wait_on(0);
      run_op(OP_TAP, 8'hff);
      chk("stacking", flag_byte, 8'h00);
      op.valid = 1'b0;
      stack_done = 1'b1;
      @(negedge sys_clk);
      stack_done = 1'b0;
      wait_on(1);
      chk("both_masks", flag_byte, 8'h50);
      chk("nmi_shut", nmi_allowed, 1'b0);
      nonmaskable_req_pin_n = 1'b1;
      for (int i = 0; i < 4; i++) begin
         if (i > 0) feed(pre[i]);
         feed(8'h3a);
         chk("page", opcode_page, i[1:0]);
         chk("opcode", {opcode_valid, opcode}, 9'h13a);
      end
      feed(PREBYTE_P1);
      feed(PREBYTE_P1);
      chk("pre_pre", {opcode_page, opcode}, {2'h1, PREBYTE_P1});
      fetch_byte.valid = 1'b0;
      {pc_load, pc_advance, pc_value} = {2'b11, 16'h1234};
      @(negedge sys_clk);
      chk("pc_load", next_fetch_pointer, 16'h1234);
      pc_load = 1'b0;
      run_op(OP_KEEP, 8'h55);
      chk("pc_step", next_fetch_pointer, 16'h1235);
      chk("keep", flag_byte, 8'h50);
      run_op(OP_RTI, 8'h80);
      chk("rti_clear", flag_byte, 8'h80);
      {op.valid, pc_advance} = 2'b00;
      {intr_recognized, intr_is_pin} = 2'b10;
      @(negedge sys_clk);
      {intr_recognized, stack_done} = 2'b01;
      @(negedge sys_clk);
      stack_done = 1'b0;
      wait_on(1);
      chk("irq_entry", flag_byte, 8'h90);
      complete_run();
   end
endmodule
bind cfrv_core cfrv_core_sva cfrv_core_sva_i (.sys_clk, .rst_n, .mem_req,
   .mem_ack, .vector_done, .op, .flag_byte, .op_result_valid, .stop_enter,
   .irq_pending, .irq_allowed, .nmi_allowed, .stack_req, .stack_done,
   .intr_vector_fetch);
